/* File: rtl/fc_pkg.sv */
// constants and carrier types for the ingress queue flow-control tracker
package fc_pkg;
	// tracked geometry: 8 classes x 8 ports x 4 sub-ports
	localparam int CLS_W  = 3;
	localparam int PORT_W = 3;
	localparam int SP_W   = 2;
	localparam int MCLS_W = 4;
	localparam int UC_N   = 256;
	localparam int MC_N   = 64;
	localparam int CS_N   = 64;
	// message layout
	localparam int MSG_W     = 27;
	localparam int LRF_BIT   = 26;
	localparam int ADR_LSB   = 4;
	localparam int ADR_W     = 20;
	localparam int GRP_LSB   = 16;
	localparam int CISP_LSB  = 20;
	localparam int MISP_LSB  = 12;
	localparam int MCLS_LSB  = 4;
	localparam int QMG_W     = 8;
	// fields inside the unicast address field
	localparam int ADR_CLS_LSB  = 0;
	localparam int ADR_SP_LSB   = 8;
	localparam int ADR_PORT_LSB = 12;
	// type codes
	localparam logic [1:0] TY_UC    = 2'h0;
	localparam logic [1:0] TY_CLS   = 2'h1;
	localparam logic [2:0] TY_MC    = 3'h4;
	localparam logic [2:0] TY_GLB   = 3'h5;
	localparam logic [1:0] TY_QM_UC = 2'h0;
	localparam logic [1:0] TY_QM_MC = 2'h1;
	localparam logic [3:0] ST_XON   = 4'hf;
	localparam logic [3:0] ST_XOFF  = 4'h0;
	// register map and control fields
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_BADCNT = 8'h08;
	localparam int CTRL_SPM     = 0;
	localparam int CTRL_CLS_EN  = 2;
	localparam int CTRL_CLS_MC  = 3;
	localparam int CTRL_GLB_EN  = 4;
	localparam int CTRL_QM_EN   = 5;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		SPM_PHYS = 2'h0,
		SPM_EGR  = 2'h1,
		SPM_FULL = 2'h3
	} spm_t;

	typedef struct packed {
		logic        awvalid;
		logic [7:0]  awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [7:0]  araddr;
		logic        rready;
	} axil_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} axil_rsp_t;

	typedef struct packed {
		logic             valid;
		logic [MSG_W-1:0] bits;
	} fc_msg_t;

	typedef struct packed {
		logic [CLS_W-1:0]  cls;
		logic [PORT_W-1:0] port;
		logic [SP_W-1:0]   esp;
		logic [SP_W-1:0]   isp;
		logic [MCLS_W-1:0] mcls;
	} fc_query_t;

	typedef struct packed {
		logic       link_ready;
		logic       uc_ok;
		logic       mc_ok;
		logic [7:0] global_code;
	} fc_result_t;
endpackage

/* File: rtl/fc_tracker.sv */
// ingress flow-control state tracker with an axi4-lite register slave
module fc_tracker (
	// clock and reset
	input  wire logic               i_clk,
	input  wire logic               i_rstn,
	// register bus
	input  wire fc_pkg::axil_req_t  i_axil,
	output fc_pkg::axil_rsp_t       o_axil,
	// decoded flow-control messages, one per valid cycle
	input  wire fc_pkg::fc_msg_t    i_msg,
	// queue lookup from the transmit scheduler
	input  wire fc_pkg::fc_query_t  i_query,
	output fc_pkg::fc_result_t      o_result
);

	////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic [fc_pkg::UC_N-1:0] uc_xon;
		logic [fc_pkg::MC_N-1:0] mc_xon;
		logic [fc_pkg::CS_N-1:0] cls_xon;
		logic                    link_ready;
		logic [7:0]              global_code;
		logic [15:0]             bad_cnt;
		logic [7:0]              ctrl;
		fc_pkg::axil_rsp_t       axil;
		logic                    aw_got;
		logic [7:0]              aw_addr;
		logic                    w_got;
		logic [31:0]             w_data;
		logic [3:0]              w_strb;
		fc_pkg::fc_result_t      res;
	} st_t;

	// queues and classes open, link closed until the first message
	localparam st_t ST_RST = '{
		uc_xon:      '1,
		mc_xon:      '1,
		cls_xon:     '1,
		link_ready:  1'b0,
		global_code: 8'h00,
		bad_cnt:     16'h0000,
		ctrl:        fc_pkg::CTRL_RST,
		axil:        '0,
		aw_got:      1'b0,
		aw_addr:     8'h00,
		w_got:       1'b0,
		w_data:      32'h0000_0000,
		w_strb:      4'h0,
		res:         '0
	};

	st_t st_q;
	st_t st_d;

	////////////////////////////////////////////////////////////////////////
	// helpers

	// sub-port setting; an illegal code falls back to port-only
	function automatic fc_pkg::spm_t spm_of(input logic [1:0] c);
		unique case (c)
			2'h1:    spm_of = fc_pkg::SPM_EGR;
			2'h3:    spm_of = fc_pkg::SPM_FULL;
			default: spm_of = fc_pkg::SPM_PHYS;
		endcase
	endfunction

	// unicast index; concatenation equals the multiply-add since
	// every count is a power of two
	function automatic logic [7:0] uc_index(
		input logic [fc_pkg::CLS_W-1:0]  cls,
		input logic [fc_pkg::PORT_W-1:0] port,
		input logic [fc_pkg::SP_W-1:0]   esp,
		input fc_pkg::spm_t              spm
	);
		if (spm == fc_pkg::SPM_PHYS) begin
			uc_index = {2'h0, cls, port};
		end else begin
			uc_index = {cls, port, esp};
		end
	endfunction

	// ingress sub-port is honoured only in the full setting
	function automatic logic [fc_pkg::SP_W-1:0] isp_eff(
		input logic [fc_pkg::SP_W-1:0] isp,
		input fc_pkg::spm_t            spm
	);
		isp_eff = (spm == fc_pkg::SPM_FULL) ? isp : '0;
	endfunction

	// status code: 1 when one of the two defined values
	function automatic logic code_ok(input logic [3:0] s);
		code_ok = (s == fc_pkg::ST_XON) || (s == fc_pkg::ST_XOFF);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// next-state logic

	logic [26:0]             m;
	logic [19:0]             adr;
	logic [3:0]              stat;
	fc_pkg::spm_t            spm;
	logic                    cls_en;
	logic                    cls_mc;
	logic                    glb_en;
	logic                    qm_en;
	logic                    bad_evt;
	logic                    bad_clr;
	logic [7:0]              ui;
	logic [5:0]              mi;
	logic [1:0]              ie;
	logic [1:0]              qi;
	logic [5:0]              ci;
	logic [5:0]              cm;
	logic [7:0]              qu;
	logic                    wr_go;
	logic                    ar_go;
	logic [31:0]             rd;
	logic                    rd_ok;

	always_comb begin
		st_d    = st_q;
		m       = i_msg.bits;
		adr     = m[fc_pkg::ADR_LSB +: fc_pkg::ADR_W];
		stat    = m[3:0];
		spm     = spm_of(st_q.ctrl[fc_pkg::CTRL_SPM +: 2]);
		cls_en  = st_q.ctrl[fc_pkg::CTRL_CLS_EN];
		cls_mc  = st_q.ctrl[fc_pkg::CTRL_CLS_MC];
		glb_en  = st_q.ctrl[fc_pkg::CTRL_GLB_EN];
		qm_en   = st_q.ctrl[fc_pkg::CTRL_QM_EN];
		bad_evt = 1'b0;
		bad_clr = 1'b0;
		ui      = uc_index(adr[fc_pkg::ADR_CLS_LSB +: fc_pkg::CLS_W],
				adr[fc_pkg::ADR_PORT_LSB +: fc_pkg::PORT_W],
				adr[fc_pkg::ADR_SP_LSB +: fc_pkg::SP_W], spm);
		ie      = isp_eff(m[fc_pkg::MISP_LSB +: fc_pkg::SP_W], spm);
		mi      = {ie, m[fc_pkg::MCLS_LSB +: fc_pkg::MCLS_W]};
		ci      = {isp_eff(m[fc_pkg::CISP_LSB +: fc_pkg::SP_W], spm), 4'h0};
		qu      = m[fc_pkg::GRP_LSB +: fc_pkg::QMG_W];
		qi      = isp_eff(i_query.isp, spm);
		cm      = {qi, i_query.mcls};
		wr_go   = 1'b0;
		ar_go   = 1'b0;
		rd      = 32'h0000_0000;
		rd_ok   = 1'b1;

		// message decode; every message refreshes the link ready bit
		if (i_msg.valid) begin
			st_d.link_ready = m[fc_pkg::LRF_BIT];
			if (qm_en) begin
				// map layouts only; others are not looked at
				if (m[25:24] == fc_pkg::TY_QM_UC) begin
					// groups beyond the tracked queues are dropped
					if (qu < 8'(fc_pkg::UC_N / 16)) begin
						st_d.uc_xon[{qu[3:0], 4'h0} +: 16] = m[15:0];
					end
				end else if (m[25:24] == fc_pkg::TY_QM_MC) begin
					if (m[19:16] == 4'h0) begin
						st_d.mc_xon[15:0] = m[15:0];
					end
				end
			end else if (m[25:24] == fc_pkg::TY_UC) begin
				if (code_ok(stat)) begin
					st_d.uc_xon[ui] = (stat == fc_pkg::ST_XON);
				end else begin
					bad_evt = 1'b1;
				end
			end else if (m[25:24] == fc_pkg::TY_CLS) begin
				// only class group 0 is tracked here
				if (cls_en && m[19:16] == 4'h0) begin
					st_d.cls_xon[ci +: 16] = m[15:0];
				end
			end else if (m[25:23] == fc_pkg::TY_MC) begin
				if (m[11:8] != 4'h0) begin
					// classes above the tracked range are ignored
				end else if (code_ok(stat)) begin
					st_d.mc_xon[mi] = (stat == fc_pkg::ST_XON);
				end else begin
					bad_evt = 1'b1;
				end
			end else if (m[25:23] == fc_pkg::TY_GLB) begin
				if (glb_en) begin
					st_d.global_code = m[7:0];
				end
			end
		end

		// lookup result, one cycle behind the query
		// link xoff wins; class xoff masks but never rewrites queue state
		st_d.res.link_ready  = st_q.link_ready;
		st_d.res.global_code = st_q.global_code;
		st_d.res.uc_ok = st_q.link_ready
				& st_q.uc_xon[uc_index(i_query.cls, i_query.port,
				i_query.esp, spm)]
				& (~cls_en | st_q.cls_xon[{qi, 1'b0, i_query.cls}]);
		st_d.res.mc_ok = st_q.link_ready & st_q.mc_xon[cm]
				& (~(cls_en & cls_mc) | st_q.cls_xon[cm]);

		// write address and data are taken in either order
		if (i_axil.awvalid && st_q.axil.awready) begin
			st_d.aw_got       = 1'b1;
			st_d.aw_addr      = i_axil.awaddr;
			st_d.axil.awready = 1'b0;
		end
		if (i_axil.wvalid && st_q.axil.wready) begin
			st_d.w_got       = 1'b1;
			st_d.w_data      = i_axil.wdata;
			st_d.w_strb      = i_axil.wstrb;
			st_d.axil.wready = 1'b0;
		end
		if (!st_q.aw_got && !st_q.axil.bvalid && !st_d.aw_got) begin
			st_d.axil.awready = 1'b1;
		end
		if (!st_q.w_got && !st_q.axil.bvalid && !st_d.w_got) begin
			st_d.axil.wready = 1'b1;
		end

		// perform the write once both halves are held
		if (st_q.aw_got && st_q.w_got) begin
			wr_go             = 1'b1;
			st_d.aw_got       = 1'b0;
			st_d.w_got        = 1'b0;
			st_d.axil.bvalid  = 1'b1;
			st_d.axil.bresp   = fc_pkg::RESP_OKAY;
			unique case (st_q.aw_addr)
				fc_pkg::REG_CTRL: begin
					if (st_q.w_strb[0]) begin
						st_d.ctrl = {2'h0, st_q.w_data[5:0]};
					end
				end
				fc_pkg::REG_BADCNT: begin
					bad_clr = st_q.w_strb[0];
				end
				fc_pkg::REG_STATUS: begin
					// read-only; write is accepted and dropped
				end
				default: begin
					st_d.axil.bresp = fc_pkg::RESP_SLVERR;
				end
			endcase
		end
		if (st_q.axil.bvalid && i_axil.bready) begin
			st_d.axil.bvalid  = 1'b0;
			st_d.axil.awready = 1'b1;
			st_d.axil.wready  = 1'b1;
		end

		// bad-code counter saturates; an event in the clear cycle wins
		if (bad_clr) begin
			st_d.bad_cnt = bad_evt ? 16'h0001 : 16'h0000;
		end else if (bad_evt && st_q.bad_cnt != 16'hffff) begin
			st_d.bad_cnt = st_q.bad_cnt + 16'h0001;
		end

		// read channel: one read at a time, answer the cycle after
		if (i_axil.arvalid && st_q.axil.arready) begin
			ar_go = 1'b1;
			unique case (i_axil.araddr)
				fc_pkg::REG_CTRL:   rd = {24'h0, st_q.ctrl};
				fc_pkg::REG_STATUS: rd = {16'h0, st_q.global_code,
						7'h0, st_q.link_ready};
				fc_pkg::REG_BADCNT: rd = {16'h0, st_q.bad_cnt};
				default:            rd_ok = 1'b0;
			endcase
			st_d.axil.arready = 1'b0;
			st_d.axil.rvalid  = 1'b1;
			st_d.axil.rdata   = rd;
			st_d.axil.rresp   = rd_ok ? fc_pkg::RESP_OKAY
					: fc_pkg::RESP_SLVERR;
		end else if (st_q.axil.rvalid && i_axil.rready) begin
			st_d.axil.rvalid  = 1'b0;
			st_d.axil.arready = 1'b1;
		end else if (!st_q.axil.rvalid) begin
			st_d.axil.arready = 1'b1;
		end
		if (wr_go || ar_go) begin
			// nothing further; strobes only feed the decode above
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registers

	// reset opens every queue and class
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			st_q <= ST_RST;
		end else begin
			st_q <= st_d;
		end
	end

	// outputs straight from the state register
	assign o_axil   = st_q.axil;
	assign o_result = st_q.res;

endmodule

/* File: dv/fc_tracker_assertions.sv */
// concurrent checks on the ports of the flow-control tracker
module fc_tracker_assertions (
	// clock and reset
	input wire logic               i_clk,
	input wire logic               i_rstn,
	// watched ports
	input wire fc_pkg::axil_req_t  i_axil,
	input wire fc_pkg::axil_rsp_t  o_axil,
	input wire fc_pkg::fc_msg_t    i_msg,
	input wire fc_pkg::fc_query_t  i_query,
	input wire fc_pkg::fc_result_t o_result
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	////////////////////////////////////////////////////////////////////
	// messages switching off exactly the queue being looked up
	sequence uc_off;
		i_msg.valid && i_msg.bits[25:24] == 2'h0 && i_msg.bits[3:0] == 4'h0
		&& i_msg.bits[6:4] == i_query.cls
		&& i_msg.bits[18:16] == i_query.port
		&& i_msg.bits[13:12] == i_query.esp;
	endsequence
	sequence mc_off;
		i_msg.valid && i_msg.bits[25:23] == 3'h4 && i_msg.bits[3:0] == 4'h0
		&& i_msg.bits[11:4] == {4'h0, i_query.mcls}
		&& i_msg.bits[15:12] == {2'h0, i_query.isp};
	endsequence
	// no later message or lookup change that could mask the effect
	sequence quiet;
		!i_msg.valid && $stable(i_query);
	endsequence
	////////////////////////////////////////////////////////////////////
	uc_xoff_a: assert property (uc_off ##1 quiet |=> !o_result.uc_ok)
		else $error("unicast xoff not applied");
	mc_xoff_a: assert property (mc_off ##1 quiet |=> !o_result.mc_ok)
		else $error("multicast xoff not applied");
	link_flag_a: assert property (i_msg.valid |->
		##2 o_result.link_ready == $past(i_msg.bits[26], 2))
		else $error("link ready does not follow bit 26");
	uc_link_a: assert property (o_result.uc_ok |-> o_result.link_ready)
		else $error("unicast open while link is off");
	mc_link_a: assert property (o_result.mc_ok |-> o_result.link_ready)
		else $error("multicast open while link is off");
	global_hold_a: assert property ($changed(o_result.global_code) |->
		$past(i_msg.valid && i_msg.bits[25:23] == 3'h5, 2))
		else $error("global code moved without a global message");
	rd_answer_a: assert property (i_axil.arvalid && o_axil.arready |=>
		o_axil.rvalid && !o_axil.arready)
		else $error("read answer late");
	wr_answer_a: assert property (i_axil.awvalid && o_axil.awready
		&& i_axil.wvalid && o_axil.wready |=> !o_axil.bvalid ##1 o_axil.bvalid)
		else $error("write answer off its slot");
endmodule

/* File: dv/fc_fabric_model.sv */
// behavioural switch fabric emitting decoded flow-control messages
module fc_fabric_model (
	// clock
	input  wire logic      i_clk,
	// message stream towards the tracker
	output fc_pkg::fc_msg_t o_msg
);
	timeunit 1ns;
	timeprecision 1ps;
	initial o_msg = '0;
	// one-cycle strobe; bits inverted after so stale data never lingers
	task automatic send(input logic [26:0] b);
		@(posedge i_clk);
		o_msg <= '{valid: 1'b1, bits: b};
		@(posedge i_clk);
		o_msg <= '{valid: 1'b0, bits: ~b};
	endtask
	// address field sits msb first in 23:4, status passed through as given, reserved codes included
	task automatic uc(input logic r, input logic [2:0] c, p,
		input logic [1:0] e, input logic [3:0] st);
		send({r, fc_pkg::TY_UC, 5'h0, p, 2'h0, e, 5'h0, c, st});
	endtask
	// class in 11:4, ingress sub-port in 15:12
	task automatic mc(input logic r, input logic [3:0] isp,
		input logic [7:0] c, input logic [3:0] st);
		send({r, fc_pkg::TY_MC, 7'h0, isp, c, st});
	endtask
	// bit n of the map is class {group, n}
	task automatic cl(input logic r, input logic [3:0] isp, g,
		input logic [15:0] m);
		send({r, fc_pkg::TY_CLS, isp, g, m});
	endtask
	task automatic gl(input logic r, input logic [7:0] code);
		send({r, fc_pkg::TY_GLB, 15'h0, code});
	endtask
endmodule

/* File: dv/ingress_queue_flow_control_tb.sv */
// self-checking bench for the flow-control tracker
module ingress_queue_flow_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic               i_clk;
	logic               i_rstn;
	fc_pkg::axil_req_t  axi;
	fc_pkg::axil_rsp_t  rsp;
	fc_pkg::fc_msg_t    msg;
	fc_pkg::fc_query_t  qry;
	fc_pkg::fc_result_t res;
	int                 err_count;
	int                 tests_run;
	fc_tracker dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_axil(axi),
		.o_axil(rsp), .i_msg(msg), .i_query(qry), .o_result(res));
	fc_fabric_model fab (.i_clk(i_clk), .o_msg(msg));
	initial begin
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end
	////////////////////////////////////////////////////////////////////
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// write: both channels offered, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		int n;
		logic aw, w;
		aw = 1'b1;
		w = 1'b1;
		n = 0;
		axi.awaddr <= a;
		axi.wdata <= d;
		axi.wstrb <= 4'hf;
		axi.awvalid <= 1'b1;
		axi.wvalid <= 1'b1;
		axi.bready <= 1'b1;
		do begin
			@(posedge i_clk);
			n++;
			if (n > 40) begin
				err_count++;
				conclude();
			end
			if (aw && rsp.awready) begin
				aw = 1'b0;
				axi.awvalid <= 1'b0;
			end
			if (w && rsp.wready) begin
				w = 1'b0;
				axi.wvalid <= 1'b0;
			end
		end while (rsp.bvalid !== 1'b1);
		axi.bready <= 1'b0;
		chk("bresp", rsp.bresp, er);
		// let an edge pass so a following write never re-drives bready
		@(posedge i_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		int n;
		n = 0;
		axi.araddr <= a;
		axi.arvalid <= 1'b1;
		axi.rready <= 1'b1;
		do begin
			@(posedge i_clk);
			n++;
			if (n > 40) begin
				err_count++;
				conclude();
			end
			if (rsp.arready) axi.arvalid <= 1'b0;
		end while (rsp.rvalid !== 1'b1);
		axi.rready <= 1'b0;
		chk("rdata", rsp.rdata, d);
		chk("rresp", rsp.rresp, er);
		// let an edge pass so a following read never re-drives rready
		@(posedge i_clk);
	endtask
	// lookup is registered, so give it a few edges to land
	task automatic look(input logic [2:0] c, p, input logic [1:0] e, i,
		input logic [3:0] m);
		qry <= '{cls: c, port: p, esp: e, isp: i, mcls: m};
		repeat (3) @(posedge i_clk);
	endtask
	////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		look(0, 0, 0, 0, 0);
		chk("link", res.link_ready, 0);
		rd(8'h00, 0, 2'h0);
		rd(8'h08, 0, 2'h0);
		rd(8'h0c, 0, 2'h2);
		wr(8'h10, 32'hff, 2'h2);
		fab.uc(1, 0, 0, 0, 4'hf);
		look(6, 6, 0, 0, 6);
		chk("uc default", res.uc_ok, 1);
		chk("mc default", res.mc_ok, 1);
		$display("test reset done");
	endtask
	task automatic t_uc();
		look(3, 5, 0, 0, 0);
		fab.uc(1, 3, 5, 0, 4'h0);
		look(3, 5, 0, 0, 0);
		chk("uc off", res.uc_ok, 0);
		look(3, 4, 0, 0, 0);
		chk("uc other", res.uc_ok, 1);
		fab.uc(1, 3, 5, 0, 4'h5);
		look(3, 5, 0, 0, 0);
		chk("uc rsvd", res.uc_ok, 0);
		rd(8'h08, 1, 2'h0);
		wr(8'h08, 0, 2'h0);
		fab.uc(1, 3, 5, 0, 4'hf);
		look(3, 5, 0, 0, 0);
		chk("uc on", res.uc_ok, 1);
		fab.uc(1, 4, 1, 2, 4'h0);
		look(4, 1, 0, 0, 0);
		chk("esp ignored", res.uc_ok, 0);
		wr(8'h00, 1, 2'h0);
		fab.uc(1, 2, 1, 1, 4'h0);
		look(2, 1, 0, 0, 0);
		chk("esp 0", res.uc_ok, 1);
		look(2, 1, 1, 0, 0);
		chk("esp 1", res.uc_ok, 0);
		$display("test unicast done");
	endtask
	task automatic t_mc();
		wr(8'h00, 0, 2'h0);
		look(0, 0, 0, 0, 9);
		fab.mc(1, 0, 8'h09, 4'h0);
		look(0, 0, 0, 0, 9);
		chk("mc off", res.mc_ok, 0);
		fab.mc(1, 2, 8'h09, 4'hf);
		look(0, 0, 0, 0, 9);
		chk("isp ignored", res.mc_ok, 1);
		fab.mc(1, 0, 8'h19, 4'h0);
		look(0, 0, 0, 0, 9);
		chk("mc high", res.mc_ok, 1);
		fab.mc(1, 0, 8'h09, 4'h3);
		rd(8'h08, 1, 2'h0);
		look(0, 0, 0, 0, 9);
		chk("mc rsvd", res.mc_ok, 1);
		wr(8'h00, 3, 2'h0);
		fab.mc(1, 1, 8'h07, 4'h0);
		look(0, 0, 0, 1, 7);
		chk("isp 1", res.mc_ok, 0);
		look(0, 0, 0, 0, 7);
		chk("isp 0", res.mc_ok, 1);
		$display("test multicast done");
	endtask
	task automatic t_cls();
		wr(8'h00, 4, 2'h0);
		fab.cl(1, 0, 0, 16'hfff7);
		look(3, 5, 0, 0, 3);
		chk("cls off", res.uc_ok, 0);
		chk("mc apart", res.mc_ok, 1);
		look(2, 5, 0, 0, 0);
		chk("cls other", res.uc_ok, 1);
		fab.uc(1, 3, 6, 0, 4'h0);
		fab.cl(1, 0, 0, 16'hffff);
		look(3, 6, 0, 0, 0);
		chk("queue kept", res.uc_ok, 0);
		look(3, 5, 0, 0, 0);
		chk("queue back", res.uc_ok, 1);
		wr(8'h00, 8'h0c, 2'h0);
		fab.cl(1, 0, 0, 16'hfff7);
		look(0, 0, 0, 0, 3);
		chk("shared", res.mc_ok, 0);
		$display("test class done");
	endtask
	task automatic t_glb();
		wr(8'h00, 0, 2'h0);
		fab.gl(1, 8'h5a);
		look(0, 0, 0, 0, 0);
		chk("glb off", res.global_code, 0);
		wr(8'h00, 8'h10, 2'h0);
		fab.gl(1, 8'h5a);
		look(0, 0, 0, 0, 0);
		chk("glb", res.global_code, 8'h5a);
		wr(8'h04, 0, 2'h0);
		rd(8'h04, 32'h5a01, 2'h0);
		fab.uc(0, 0, 0, 0, 4'hf);
		look(0, 0, 0, 0, 0);
		chk("link off", res.link_ready, 0);
		fab.uc(1, 0, 0, 0, 4'hf);
		$display("test global done");
	endtask
	// map index cls*8+port: queue (1,2) is bit 10 of group 0
	task automatic t_qm();
		wr(8'h00, 8'h30, 2'h0);
		fab.send({1'b1, 2'h0, 8'h00, 16'hfbff});
		look(1, 2, 0, 0, 0);
		chk("map off", res.uc_ok, 0);
		look(1, 3, 0, 0, 0);
		chk("map on", res.uc_ok, 1);
		fab.gl(1, 8'h11);
		look(0, 0, 0, 0, 0);
		chk("map only", res.global_code, 8'h5a);
		// multicast map, group 0: class 5 off, the rest on
		fab.send({1'b1, 2'h1, 8'h00, 16'hffdf});
		look(0, 0, 0, 0, 5);
		chk("mc map off", res.mc_ok, 0);
		look(0, 0, 0, 0, 4);
		chk("mc map on", res.mc_ok, 1);
		$display("test queue map done");
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		axi = '0;
		qry = '0;
		i_rstn = 1'b0;
		err_count = 0;
		tests_run = 0;
		repeat (10) @(posedge i_clk);
		i_rstn <= 1'b1;
		@(posedge i_clk);
		t_reset();
		t_uc();
		t_mc();
		t_cls();
		t_glb();
		t_qm();
		conclude();
	end
endmodule
bind fc_tracker fc_tracker_assertions chk_i (.i_clk(i_clk),
	.i_rstn(i_rstn), .i_axil(i_axil), .o_axil(o_axil), .i_msg(i_msg),
	.i_query(i_query), .o_result(o_result));
